// ---- rtl/iaic_core.sv ----
/*
  arbitration-lost flag, bus-busy tracking, interrupt cause code, prescaler
  and serial clock low/high shaping. assumes the shift, address and data
  paths report arbitration loss, no-acknowledge, start and stop as one-cycle
  pulses, and ready flags as levels, all synchronous to mclk.
*/
`timescale 1ns/10ps

module iaic_core
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic io_sel,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [2:0] io_addr,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  input wire logic arb_lost_evt,
  input wire logic nack_evt,
  input wire logic start_det,
  input wire logic stop_det,
  input wire logic ardy_in,
  input wire logic rrdy_in,
  input wire logic xrdy_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic mod_tick,
  output logic module_out_of_reset,
  output logic master_select,
  output logic stop_request,
  output logic bus_busy_flag,
  output logic arb_lost_irq
);

  logic irs_r, irs_nxt, mst_r, mst_nxt, stp_r, stp_nxt;
  logic al_r, al_nxt, nack_r, nack_nxt, bb_r, bb_nxt;
  logic [3:0] test_field_r, test_field_nxt;
  logic [7:0] psc_r, psc_nxt, psc_act_r, psc_act_nxt, pre_cnt_r, pre_cnt_nxt;
  logic [15:0] scl_low_divisor_r, scl_low_nxt, scl_high_divisor_r, scl_high_nxt;
  logic [15:0] rdata_nxt;
  logic wr_mode, wr_stat, wr_cause, wr_psc, wr_clkl, wr_clkh, rd_cause;
  logic start_busy, al_set, tick_nxt;
  logic [2:0] interrupt_cause_code;
  logic [3:0] dly;
  logic [16:0] low_len, high_len, ph_cnt_r, ph_cnt_nxt;
  iaic_pkg::iaic_phase_t st_r, st_nxt;
  logic scl_oe_n_nxt;

  assign wr_mode = io_sel && io_wr && io_addr == iaic_pkg::OFF_MODE;
  assign wr_stat = io_sel && io_wr && io_addr == iaic_pkg::OFF_STATUS;
  assign wr_cause = io_sel && io_wr && io_addr == iaic_pkg::OFF_CAUSE;
  assign wr_psc = io_sel && io_wr && io_addr == iaic_pkg::OFF_PSC;
  assign wr_clkl = io_sel && io_wr && io_addr == iaic_pkg::OFF_CLKL;
  assign wr_clkh = io_sel && io_wr && io_addr == iaic_pkg::OFF_CLKH;
  assign rd_cause = io_sel && io_rd && io_addr == iaic_pkg::OFF_CAUSE;

  // start asked while bus busy
  assign start_busy = wr_mode && io_wdata[iaic_pkg::MODE_MST_BIT] && !mst_r
    && bb_r && irs_r;
  assign al_set = irs_r && ((arb_lost_evt && mst_r) || start_busy);

  // cause code, highest priority first
  always_comb
  begin
    if (al_r)
      interrupt_cause_code = iaic_pkg::CODE_AL;
    else if (nack_r)
      interrupt_cause_code = iaic_pkg::CODE_NACK;
    else if (ardy_in)
      interrupt_cause_code = iaic_pkg::CODE_ARDY;
    else if (rrdy_in)
      interrupt_cause_code = iaic_pkg::CODE_RRDY;
    else if (xrdy_in)
      interrupt_cause_code = iaic_pkg::CODE_XRDY;
    else
      interrupt_cause_code = iaic_pkg::CODE_NONE;
  end

  // control and flags
  always_comb
  begin
    irs_nxt = irs_r;
    mst_nxt = mst_r;
    stp_nxt = stp_r;
    al_nxt = al_r;
    nack_nxt = nack_r;
    bb_nxt = bb_r;
    test_field_nxt = test_field_r;
    psc_nxt = psc_r;
    psc_act_nxt = psc_act_r;
    scl_low_nxt = scl_low_divisor_r;
    scl_high_nxt = scl_high_divisor_r;
    if (wr_mode)
    begin
      irs_nxt = io_wdata[iaic_pkg::MODE_IRS_BIT];
      mst_nxt = io_wdata[iaic_pkg::MODE_MST_BIT] && !start_busy;
      stp_nxt = io_wdata[iaic_pkg::MODE_STP_BIT];
    end
    if (wr_stat && io_wdata[iaic_pkg::STAT_AL_BIT])
      al_nxt = 1'b0;
    if (rd_cause && interrupt_cause_code == iaic_pkg::CODE_AL)
      al_nxt = 1'b0;
    if (wr_stat && io_wdata[iaic_pkg::STAT_NACK_BIT])
      nack_nxt = 1'b0;
    if (rd_cause && interrupt_cause_code == iaic_pkg::CODE_NACK)
      nack_nxt = 1'b0;
    if (wr_stat && io_wdata[iaic_pkg::STAT_BB_BIT])
      bb_nxt = 1'b0;
    // start/stop seen only out of reset
    if (irs_r && stop_det)
      bb_nxt = 1'b0;
    if (irs_r && start_det)
      bb_nxt = 1'b1;
    if (irs_r && nack_evt)
      nack_nxt = 1'b1;
    if (al_set)
    begin
      al_nxt = 1'b1;
      mst_nxt = 1'b0;
      stp_nxt = 1'b0;
    end
    if (!irs_r)
    begin
      al_nxt = 1'b0;
      nack_nxt = 1'b0;
    end
    if (wr_cause)
      test_field_nxt = io_wdata[iaic_pkg::CAUSE_TEST_MSB:iaic_pkg::CAUSE_TEST_LSB];
    if (wr_psc && !irs_r)
      psc_nxt = io_wdata[7:0];
    if (wr_mode && io_wdata[iaic_pkg::MODE_IRS_BIT] && !irs_r)
      psc_act_nxt = psc_r;
    if (wr_clkl)
      scl_low_nxt = io_wdata;
    if (wr_clkh)
      scl_high_nxt = io_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irs_r <= iaic_pkg::MODE_RST[iaic_pkg::MODE_IRS_BIT];
      mst_r <= iaic_pkg::MODE_RST[iaic_pkg::MODE_MST_BIT];
      stp_r <= iaic_pkg::MODE_RST[iaic_pkg::MODE_STP_BIT];
      al_r <= 1'b0;
      nack_r <= 1'b0;
      bb_r <= 1'b0;
      test_field_r <= 4'h0;
      psc_r <= iaic_pkg::PSC_RST;
      psc_act_r <= iaic_pkg::PSC_RST;
      scl_low_divisor_r <= iaic_pkg::CLKL_RST;
      scl_high_divisor_r <= iaic_pkg::CLKH_RST;
    end
    else
    begin
      irs_r <= irs_nxt;
      mst_r <= mst_nxt;
      stp_r <= stp_nxt;
      al_r <= al_nxt;
      nack_r <= nack_nxt;
      bb_r <= bb_nxt;
      test_field_r <= test_field_nxt;
      psc_r <= psc_nxt;
      psc_act_r <= psc_act_nxt;
      scl_low_divisor_r <= scl_low_nxt;
      scl_high_divisor_r <= scl_high_nxt;
    end
  end

  // read data
  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (io_sel && io_rd)
    begin
      unique case (io_addr)
        iaic_pkg::OFF_MODE: rdata_nxt = {13'h0000, stp_r, mst_r, irs_r};
        iaic_pkg::OFF_STATUS: rdata_nxt = {3'h0, bb_r, 7'h00, xrdy_in, rrdy_in,
          ardy_in, nack_r, al_r};
        iaic_pkg::OFF_CAUSE: rdata_nxt = {4'h0, test_field_r, 5'h00,
          interrupt_cause_code};
        iaic_pkg::OFF_PSC: rdata_nxt = {8'h00, psc_r};
        iaic_pkg::OFF_CLKL: rdata_nxt = scl_low_divisor_r;
        iaic_pkg::OFF_CLKH: rdata_nxt = scl_high_divisor_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // prescaler and delay constant
  always_comb
  begin
    pre_cnt_nxt = 8'h00;
    tick_nxt = 1'b0;
    if (irs_r)
    begin
      if (pre_cnt_r == psc_act_r)
        tick_nxt = 1'b1;
      else
        pre_cnt_nxt = 8'(pre_cnt_r + 8'h01);
    end
    if (psc_act_r == 8'h00)
      dly = iaic_pkg::DLY_PSC0;
    else if (psc_act_r == 8'h01)
      dly = iaic_pkg::DLY_PSC1;
    else
      dly = iaic_pkg::DLY_PSCN;
    low_len = {1'b0, scl_low_divisor_r} + {13'h0000, dly};
    high_len = {1'b0, scl_high_divisor_r} + {13'h0000, dly};
  end

  // serial clock phase engine
  always_comb
  begin
    st_nxt = st_r;
    ph_cnt_nxt = ph_cnt_r;
    if (!(irs_r && mst_r))
    begin
      st_nxt = iaic_pkg::PH_IDLE;
      ph_cnt_nxt = iaic_pkg::PHASE_CNT_RST;
    end
    else if (mod_tick)
    begin
      unique case (st_r)
        iaic_pkg::PH_IDLE:
        begin
          st_nxt = iaic_pkg::PH_LOW;
          ph_cnt_nxt = low_len;
        end
        iaic_pkg::PH_LOW:
        begin
          if (ph_cnt_r == 17'h00001)
          begin
            st_nxt = iaic_pkg::PH_HIGH;
            ph_cnt_nxt = high_len;
          end
          else
            ph_cnt_nxt = 17'(ph_cnt_r - 17'h00001);
        end
        iaic_pkg::PH_HIGH:
        begin
          if (ph_cnt_r == 17'h00001)
          begin
            st_nxt = iaic_pkg::PH_LOW;
            ph_cnt_nxt = low_len;
          end
          else
            ph_cnt_nxt = 17'(ph_cnt_r - 17'h00001);
        end
        default:
        begin
          st_nxt = iaic_pkg::PH_IDLE;
          ph_cnt_nxt = iaic_pkg::PHASE_CNT_RST;
        end
      endcase
    end
    scl_oe_n_nxt = st_nxt != iaic_pkg::PH_LOW;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pre_cnt_r <= 8'h00;
      mod_tick <= 1'b0;
      st_r <= iaic_pkg::PH_IDLE;
      ph_cnt_r <= iaic_pkg::PHASE_CNT_RST;
      scl_oe_n <= 1'b1;
      io_rdata <= 16'h0000;
    end
    else
    begin
      pre_cnt_r <= pre_cnt_nxt;
      mod_tick <= tick_nxt;
      st_r <= st_nxt;
      ph_cnt_r <= ph_cnt_nxt;
      scl_oe_n <= scl_oe_n_nxt;
      io_rdata <= rdata_nxt;
    end
  end

  assign scl_out = 1'b0;
  assign module_out_of_reset = irs_r;
  assign master_select = mst_r;
  assign stop_request = stp_r;
  assign bus_busy_flag = bb_r;
  assign arb_lost_irq = al_r;

  // checks
  logic [16:0] ph_ticks_r;
  always_ff @(posedge mclk)
  begin
    if (rst || st_r != st_nxt)
      ph_ticks_r <= 17'h00000;
    else if (mod_tick)
      ph_ticks_r <= 17'(ph_ticks_r + 17'h00001);
  end

  sequence s_low_end;
    st_r == iaic_pkg::PH_LOW && st_nxt == iaic_pkg::PH_HIGH;
  endsequence
  sequence s_high_end;
    st_r == iaic_pkg::PH_HIGH && st_nxt == iaic_pkg::PH_LOW;
  endsequence

  a_al_on_arb: assert property (@(posedge mclk) disable iff (rst)
    irs_r && mst_r && arb_lost_evt |=> al_r && !mst_r)
    else $error("arbitration loss not flagged");
  a_al_busy_start: assert property (@(posedge mclk) disable iff (rst)
    start_busy |=> al_r && !mst_r)
    else $error("start while busy not flagged");
  a_al_drops_master: assert property (@(posedge mclk) disable iff (rst)
    $rose(al_r) |-> !mst_r && !stp_r)
    else $error("master or stop left set on arbitration loss");
  a_al_read_clear: assert property (@(posedge mclk) disable iff (rst)
    rd_cause && al_r && !al_set |=> !al_r ##1 io_rdata[2:0] != iaic_pkg::CODE_AL || al_r)
    else $error("cause read did not clear arbitration flag");
  a_nack_read_clear: assert property (@(posedge mclk) disable iff (rst)
    rd_cause && !al_r && nack_r && !nack_evt |=> !nack_r
      && io_rdata[2:0] == iaic_pkg::CODE_NACK)
    else $error("cause read did not clear nack");
  a_bb_hold_reset: assert property (@(posedge mclk) disable iff (rst)
    !irs_r && !(wr_stat && io_wdata[iaic_pkg::STAT_BB_BIT]) |=> $stable(bb_r))
    else $error("bus busy changed during module reset");
  a_cause_reserved: assert property (@(posedge mclk) disable iff (rst)
    rd_cause |=> io_rdata[15:12] == 4'h0 && io_rdata[7:3] == 5'h00
      && io_rdata[2:0] <= iaic_pkg::CODE_XRDY)
    else $error("cause reserved bits not zero");
  a_psc_lock: assert property (@(posedge mclk) disable iff (rst)
    irs_r && $past(irs_r) |-> $stable(psc_act_r))
    else $error("prescale changed while out of reset");
  a_tick_period: assert property (@(posedge mclk) disable iff (rst)
    irs_r && mod_tick && psc_act_r == 8'h02 |=> !mod_tick [*2] ##1 (mod_tick || !$past(irs_r)))
    else $error("module clock period wrong");
  a_delay_const: assert property (@(posedge mclk) disable iff (rst)
    low_len - {1'b0, scl_low_divisor_r} == (psc_act_r == 8'h00 ? 17'd7 :
      psc_act_r == 8'h01 ? 17'd6 : 17'd5))
    else $error("delay constant wrong");
  a_scl_low_len: assert property (@(posedge mclk) disable iff (rst)
    s_low_end |-> 17'(ph_ticks_r + 17'h00001) == low_len)
    else $error("low phase length wrong");
  a_scl_high_len: assert property (@(posedge mclk) disable iff (rst)
    s_high_end |-> 17'(ph_ticks_r + 17'h00001) == high_len)
    else $error("high phase length wrong");
  a_scl_master_only: assert property (@(posedge mclk) disable iff (rst)
    !(irs_r && mst_r) |=> scl_oe_n)
    else $error("serial clock driven while not master");

endmodule

// ---- include/iaic_pkg.sv ----
/*
  constants for the two-wire arbitration, cause code and clock shaping block.
  assumes a 16-bit i/o register port and one input clock mclk.
*/
package iaic_pkg;
  // register offsets in i/o space
  localparam logic [2:0] OFF_MODE = 3'h0;
  localparam logic [2:0] OFF_STATUS = 3'h1;
  localparam logic [2:0] OFF_CAUSE = 3'h2;
  localparam logic [2:0] OFF_PSC = 3'h3;
  localparam logic [2:0] OFF_CLKL = 3'h4;
  localparam logic [2:0] OFF_CLKH = 3'h5;
  // mode register fields
  localparam int MODE_IRS_BIT = 0;
  localparam int MODE_MST_BIT = 1;
  localparam int MODE_STP_BIT = 2;
  // status register fields
  localparam int STAT_AL_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_ARDY_BIT = 2;
  localparam int STAT_RRDY_BIT = 3;
  localparam int STAT_XRDY_BIT = 4;
  localparam int STAT_BB_BIT = 12;
  // cause register fields
  localparam int CAUSE_TEST_LSB = 8;
  localparam int CAUSE_TEST_MSB = 11;
  // cause codes
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_AL = 3'h1;
  localparam logic [2:0] CODE_NACK = 3'h2;
  localparam logic [2:0] CODE_ARDY = 3'h3;
  localparam logic [2:0] CODE_RRDY = 3'h4;
  localparam logic [2:0] CODE_XRDY = 3'h5;
  // delay constant per prescale value
  localparam logic [3:0] DLY_PSC0 = 4'h7;
  localparam logic [3:0] DLY_PSC1 = 4'h6;
  localparam logic [3:0] DLY_PSCN = 4'h5;
  // reset values
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [7:0] PSC_RST = 8'h00;
  localparam logic [15:0] CLKL_RST = 16'h0000;
  localparam logic [15:0] CLKH_RST = 16'h0000;
  localparam logic [16:0] PHASE_CNT_RST = 17'h00000;
  // serial clock phases
  typedef enum logic [2:0]
  {
    PH_IDLE = 3'b001,
    PH_LOW = 3'b010,
    PH_HIGH = 3'b100
  } iaic_phase_t;
endpackage

// ---- tb/iaic_bus_peer.sv ----
/*
  model of the other masters and slaves on the two-wire bus.
  assumes the core samples its event inputs on the rising edge of mclk.
*/
`timescale 1ns/10ps
module iaic_bus_peer
(
  input wire logic mclk,
  input wire logic scl_oe_n,
  output logic scl_in,
  output logic start_det,
  output logic stop_det,
  output logic arb_lost_evt,
  output logic nack_evt
);
  // released clock line floats to the pull-up level
  assign scl_in = scl_oe_n ? 1'b1 : 1'b0;
  initial
  begin
    start_det = 1'b0;
    stop_det = 1'b0;
    arb_lost_evt = 1'b0;
    nack_evt = 1'b0;
  end
  // one-cycle bus event: 0 start, 1 stop, 2 lost arbitration, 3 no-ack
  task automatic pulse(input int kind);
  begin
    @(negedge mclk);
    start_det = (kind == 0);
    stop_det = (kind == 1);
    arb_lost_evt = (kind == 2);
    nack_evt = (kind == 3);
    @(negedge mclk);
    start_det = 1'b0;
    stop_det = 1'b0;
    arb_lost_evt = 1'b0;
    nack_evt = 1'b0;
  end
  endtask
endmodule

// ---- tb/tb_top.sv ----
/*
  self-checking bench for the arbitration, cause code and clock shaping core.
  assumes the core and package as delivered; bus peer model in its own file.
*/
`timescale 1ns/10ps
module tb_top;
  typedef struct
  {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } iaic_row_t;
  logic mclk, rst, io_sel, io_wr, io_rd, ardy_in, rrdy_in, xrdy_in;
  logic [2:0] io_addr;
  logic [15:0] io_wdata, io_rdata;
  logic scl_in, scl_out, scl_oe_n, mod_tick, module_out_of_reset, master_select;
  logic stop_request, bus_busy_flag, arb_lost_irq;
  logic arb_lost_evt, nack_evt, start_det, stop_det;
  int miscompares, tests_run, bad, d;
  iaic_row_t rows [6] = '{
    '{iaic_pkg::OFF_CAUSE, 16'hF0F8, 16'h0000},
    '{iaic_pkg::OFF_PSC, 16'hABCD, 16'h00CD},
    '{iaic_pkg::OFF_CLKL, 16'h1234, 16'h1234},
    '{iaic_pkg::OFF_CLKH, 16'hFFFF, 16'hFFFF},
    '{3'h6, 16'hFFFF, 16'h0000},
    '{3'h7, 16'h5A5A, 16'h0000}};
  int rdy_in [3] = '{1, 3, 7};
  int rdy_code [3] = '{5, 4, 3};

  iaic_core u_dut (.mclk(mclk), .rst(rst), .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .arb_lost_evt(arb_lost_evt), .nack_evt(nack_evt), .start_det(start_det),
    .stop_det(stop_det), .ardy_in(ardy_in), .rrdy_in(rrdy_in), .xrdy_in(xrdy_in),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .mod_tick(mod_tick),
    .module_out_of_reset(module_out_of_reset), .master_select(master_select),
    .stop_request(stop_request), .bus_busy_flag(bus_busy_flag),
    .arb_lost_irq(arb_lost_irq));
  iaic_bus_peer u_peer (.mclk(mclk), .scl_oe_n(scl_oe_n), .scl_in(scl_in),
    .start_det(start_det), .stop_det(stop_det), .arb_lost_evt(arb_lost_evt),
    .nack_evt(nack_evt));

  always #10 mclk = ~mclk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] v);
  begin
    @(negedge mclk);
    {io_sel, io_wr, io_addr, io_wdata} = {2'b11, a, v};
    @(negedge mclk);
    {io_sel, io_wr} = 2'b00;
  end
  endtask

  // read data is registered, so it is sampled one cycle after the strobe
  task automatic rdc(input logic [2:0] a, input logic [15:0] exp);
  begin
    @(negedge mclk);
    {io_sel, io_rd, io_addr} = {2'b11, a};
    @(negedge mclk);
    {io_sel, io_rd} = 2'b00;
    chk(io_rdata, exp);
  end
  endtask

  // length of one low and the following high phase, in mclk cycles
  task automatic meas(input int lo, input int hi);
    int n;
  begin
    for (n = 0; n < 9000 && scl_oe_n !== 1'b1; n++) @(negedge mclk);
    for (n = 0; n < 9000 && scl_oe_n !== 1'b0; n++) @(negedge mclk);
    chk({15'h0000, scl_in}, 16'h0000);
    for (n = 0; n < 9000 && scl_oe_n === 1'b0; n++) @(negedge mclk);
    chk(16'(n), 16'(lo));
    for (n = 0; n < 9000 && scl_oe_n === 1'b1; n++) @(negedge mclk);
    chk(16'(n), 16'(hi));
  end
  endtask

  task automatic complete_run;
  begin
    if (miscompares == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  initial
  begin
    #1000000;
    miscompares++;
    complete_run();
  end

  initial
  begin
    {mclk, rst, io_sel, io_wr, io_rd, io_addr, io_wdata} = {2'b01, 22'h000000};
    {ardy_in, rrdy_in, xrdy_in} = 3'b000;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    for (int a = 0; a < 6; a++)
      rdc(3'(a), 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      wr(rows[i].addr, rows[i].wdata);
      rdc(rows[i].addr, rows[i].exp);
    end
    wr(iaic_pkg::OFF_CLKL, 16'h0001);
    wr(iaic_pkg::OFF_CLKH, 16'h0002);
    for (int p = 0; p < 3; p++)
    begin
      d = (p == 0) ? 7 : ((p == 1) ? 6 : 5);
      wr(iaic_pkg::OFF_MODE, 16'h0000);
      wr(iaic_pkg::OFF_PSC, 16'(p));
      wr(iaic_pkg::OFF_MODE, 16'h0003);
      meas((1 + d) * (p + 1), (2 + d) * (p + 1));
    end
    wr(iaic_pkg::OFF_PSC, 16'h0000);
    meas(18, 21);
    rdc(iaic_pkg::OFF_PSC, 16'h0002);
    wr(iaic_pkg::OFF_MODE, 16'h0001);
    bad = 0;
    d = 0;
    repeat (3) @(negedge mclk);
    repeat (60)
    begin
      @(negedge mclk);
      if (scl_oe_n !== 1'b1)
        bad = 1;
      if (mod_tick === 1'b1)
        d++;
    end
    chk(16'(bad), 16'h0000);
    chk(16'(d), 16'h0014);
    chk({13'h0000, scl_out, scl_in, module_out_of_reset}, 16'h0003);
    u_peer.pulse(0);
    wr(iaic_pkg::OFF_MODE, 16'h0003);
    chk({arb_lost_irq, master_select}, 2'b10);
    rdc(iaic_pkg::OFF_CAUSE, 16'h0001);
    rdc(iaic_pkg::OFF_CAUSE, 16'h0000);
    rdc(iaic_pkg::OFF_STATUS, 16'h1000);
    u_peer.pulse(1);
    wr(iaic_pkg::OFF_MODE, 16'h0007);
    chk({master_select, stop_request}, 2'b11);
    u_peer.pulse(2);
    chk({arb_lost_irq, master_select, stop_request}, 3'b100);
    rdc(iaic_pkg::OFF_STATUS, 16'h0001);
    wr(iaic_pkg::OFF_STATUS, 16'h0001);
    rdc(iaic_pkg::OFF_STATUS, 16'h0000);
    u_peer.pulse(3);
    rdc(iaic_pkg::OFF_CAUSE, 16'h0002);
    rdc(iaic_pkg::OFF_CAUSE, 16'h0000);
    wr(iaic_pkg::OFF_MODE, 16'h0003);
    u_peer.pulse(2);
    wr(iaic_pkg::OFF_MODE, 16'h0000);
    @(negedge mclk);
    chk(16'(arb_lost_irq), 16'h0000);
    u_peer.pulse(0);
    chk(16'(bus_busy_flag), 16'h0000);
    wr(iaic_pkg::OFF_MODE, 16'h0001);
    u_peer.pulse(0);
    wr(iaic_pkg::OFF_MODE, 16'h0000);
    u_peer.pulse(1);
    wr(iaic_pkg::OFF_MODE, 16'h0001);
    chk(16'(bus_busy_flag), 16'h0001);
    u_peer.pulse(1);
    repeat (50) @(negedge mclk);
    chk(16'(bus_busy_flag), 16'h0000);
    wr(iaic_pkg::OFF_MODE, 16'h0003);
    chk({arb_lost_irq, master_select}, 2'b01);
    for (int i = 0; i < 3; i++)
    begin
      {ardy_in, rrdy_in, xrdy_in} = 3'(rdy_in[i]);
      rdc(iaic_pkg::OFF_CAUSE, 16'(rdy_code[i]));
    end
    complete_run();
  end
endmodule
